/* stp_map.svh */
// constants of the serial stepper control logic
`ifndef STP_MAP_SVH
`define STP_MAP_SVH

// control word layout
`define STP_WORD_W 8
`define STP_POL_A_BIT 0
`define STP_ON_A_BIT 1
`define STP_POL_B_BIT 2
`define STP_ON_B_BIT 3
`define STP_TRQ_LSB 4
`define STP_TRQ_MSB 7
`define STP_WORD_RST 8'h00

// current ratio
`define STP_PCT_W 7
`define STP_PCT_FULL 7'h64
`define STP_PCT_RST 7'h00

// wake-up hold-off after standby release
`define STP_CLK_MHZ 50
`define STP_WAKE_NS 10000
`define STP_WAKE_CYC ((`STP_WAKE_NS * `STP_CLK_MHZ) / 1000)
`define STP_WAKE_W 10

`endif

/* stp_pkg.sv */
// types of the serial stepper control logic
package stp_pkg;

  // stored control word, msb first
  typedef struct packed {
    logic [3:0] torque;
    logic drive_on_b;
    logic polarity_b;
    logic drive_on_a;
    logic polarity_a;
  } ctrl_word_s;

  // on state of the four bridge transistors
  typedef struct packed {
    logic a_pos;
    logic a_neg;
    logic b_pos;
    logic b_neg;
  } bridge_s;

  // power sequencing
  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_WAKE,
    ST_RUN
  } pwr_state_e;

endpackage

/* stp_sync.sv */
// two flip-flop level synchroniser
`timescale 1ns/1ns
module stp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds the second only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

/* stp_shift.sv */
// serial shift stages on the link clock
`timescale 1ns/1ns
`include "stp_map.svh"
module stp_shift
  import stp_pkg::*;
(
  input wire logic link_clk,
  input wire logic clr_n,
  input wire logic ser_data,
  output logic [`STP_WORD_W-1:0] shift_q,
  output logic chain_data_q
);

  logic [`STP_WORD_W-1:0] shift_d;

  // new bit enters stage 0, the rest move up
  assign shift_d = {shift_q[`STP_WORD_W-2:0], ser_data};

  // clear acts without waiting for a clock edge
  always_ff @(posedge link_clk or negedge clr_n) begin
    if (!clr_n) begin
      shift_q <= `STP_WORD_RST;
    end else begin
      shift_q <= shift_d;
    end
  end

  // last stage launched on falling edge, half a cycle late
  always_ff @(negedge link_clk or negedge clr_n) begin
    if (!clr_n) begin
      chain_data_q <= 1'b0;
    end else begin
      chain_data_q <= shift_q[`STP_WORD_W-1];
    end
  end

endmodule

/* stp_top.sv */
// serial stepper control logic, top level
`timescale 1ns/1ns
`include "stp_map.svh"
module stp_top
  import stp_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic LINK_CLK,
  input wire logic SER_DATA,
  input wire logic LATCH,
  input wire logic REGISTER_CLEAR_N,
  input wire logic GATE,
  input wire logic BRAKE,
  input wire logic STANDBY,
  input wire logic CC_ACTIVE,
  input wire logic MOTOR_POWER_OK,
  input wire logic OVERCURRENT_DET,
  input wire logic OVERHEAT_DET,
  input wire logic TEMP_HOT,
  input wire logic TEMP_COOL,
  output logic CHAIN_DATA_OUT,
  output logic CHAINED_CLOCK_OUT,
  output logic CHAINED_LATCH_OUT,
  output stp_pkg::bridge_s BRIDGE_ON,
  output logic [`STP_PCT_W-1:0] CURRENT_PCT,
  output logic OSC_RUN,
  output logic FAULT_N_O,
  output logic FAULT_N_OE_N,
  output logic THERMAL_WARN_N_O,
  output logic THERMAL_WARN_N_OE_N
);

  import stp_pkg::*;

  // torque field to percent of set peak, torque_bit_1 weighs most
  function automatic logic [`STP_PCT_W-1:0] trq_ratio(
    input logic [3:0] code
  );
    logic [`STP_PCT_W-1:0] pct;
    pct = `STP_PCT_RST;
    case ({code[0], code[1], code[2], code[3]})
      4'h0: pct = 7'h00;
      4'h1: pct = 7'h05;
      4'h2: pct = 7'h0a;
      4'h3: pct = 7'h0f;
      4'h4: pct = 7'h19;
      4'h5: pct = 7'h1d;
      4'h6: pct = 7'h26;
      4'h7: pct = 7'h2b;
      4'h8: pct = 7'h34;
      4'h9: pct = 7'h3c;
      4'ha: pct = 7'h43;
      4'hb: pct = 7'h4a;
      4'hc: pct = 7'h50;
      4'hd: pct = 7'h56;
      4'he: pct = 7'h5e;
      default: pct = `STP_PCT_FULL;
    endcase
    return pct;
  endfunction

  // on states of one channel
  function automatic logic [1:0] chan_drive(
    input logic on,
    input logic pol
  );
    return {on & pol, on & ~pol};
  endfunction

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------

  logic rst_meta_q;
  logic rst_n_q;

  // async assert, two-flop release
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // link domain: shift stages and chaining
  // ------------------------------------------------------------------

  wire link_clr_n;
  wire [`STP_WORD_W-1:0] shift_word;
  wire chain_data;

  // clear pin zeroes the stages at once
  assign link_clr_n = ARST_N & REGISTER_CLEAR_N;

  stp_shift u_shift (
    .link_clk(LINK_CLK),
    .clr_n(link_clr_n),
    .ser_data(SER_DATA),
    .shift_q(shift_word),
    .chain_data_q(chain_data)
  );

  // forwarded signals for the next device down
  assign CHAIN_DATA_OUT = chain_data;
  assign CHAINED_CLOCK_OUT = LINK_CLK;
  assign CHAINED_LATCH_OUT = LATCH;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------

  localparam int PIN_W = 10;

  wire [PIN_W-1:0] pin_raw;
  wire [PIN_W-1:0] pin_s;
  wire [`STP_WORD_W-1:0] word_s;

  // level pins into the system domain
  assign pin_raw = {
    LATCH,
    GATE,
    BRAKE,
    STANDBY,
    CC_ACTIVE,
    MOTOR_POWER_OK,
    OVERCURRENT_DET,
    OVERHEAT_DET,
    TEMP_HOT,
    TEMP_COOL
  };

  stp_sync #(.W(PIN_W)) u_pin_sync (
    .clk(CLK_SYS),
    .rst_n(rst_n_q),
    .d(pin_raw),
    .q(pin_s)
  );

  // shift word is idle while the latch is raised
  stp_sync #(.W(`STP_WORD_W)) u_word_sync (
    .clk(CLK_SYS),
    .rst_n(rst_n_q),
    .d(shift_word),
    .q(word_s)
  );

  wire latch_s;
  wire gate_s;
  wire brake_s;
  wire standby_s;
  wire cc_s;
  wire power_ok_s;
  wire overcurrent_s;
  wire overheat_s;
  wire hot_s;
  wire cool_s;

  // named copies of synchronised pins
  assign latch_s = pin_s[9];
  assign gate_s = pin_s[8];
  assign brake_s = pin_s[7];
  assign standby_s = pin_s[6];
  assign cc_s = pin_s[5];
  assign power_ok_s = pin_s[4];
  assign overcurrent_s = pin_s[3];
  assign overheat_s = pin_s[2];
  assign hot_s = pin_s[1];
  assign cool_s = pin_s[0];

  // ------------------------------------------------------------------
  // storage stage
  // ------------------------------------------------------------------

  logic latch_prev_q;
  logic [`STP_WORD_W-1:0] store_q;
  logic [`STP_WORD_W-1:0] store_d;

  wire latch_rise;
  wire store_clr_n;

  // rising latch loads, otherwise hold
  assign latch_rise = latch_s & ~latch_prev_q;
  assign store_d = latch_rise ? word_s : store_q;
  assign store_clr_n = rst_n_q & REGISTER_CLEAR_N;

  // latch edge detector
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      latch_prev_q <= 1'b0;
    end else begin
      latch_prev_q <= latch_s;
    end
  end

  // storage word, cleared straight from the pin
  always_ff @(posedge CLK_SYS or negedge store_clr_n) begin
    if (!store_clr_n) begin
      store_q <= `STP_WORD_RST;
    end else begin
      store_q <= store_d;
    end
  end

  // ------------------------------------------------------------------
  // power sequencing
  // ------------------------------------------------------------------

  pwr_state_e state_q;
  pwr_state_e state_d;
  logic [`STP_WAKE_W-1:0] wake_cnt_q;
  logic [`STP_WAKE_W-1:0] wake_cnt_d;

  wire wake_done;

  assign wake_done = (wake_cnt_q == `STP_WAKE_W'(`STP_WAKE_CYC - 1));

  // standby low sleeps, release waits out wake-up
  always_comb begin
    state_d = state_q;
    wake_cnt_d = '0;
    case (state_q)
      ST_SLEEP: begin
        if (standby_s) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        wake_cnt_d = wake_cnt_q + `STP_WAKE_W'(1);
        if (!standby_s) begin
          state_d = ST_SLEEP;
        end else if (wake_done) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        if (!standby_s) begin
          state_d = ST_SLEEP;
        end
      end
    endcase
  end

  // state and wake counter
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= ST_SLEEP;
      wake_cnt_q <= '0;
    end else begin
      state_q <= state_d;
      wake_cnt_q <= wake_cnt_d;
    end
  end

  // ------------------------------------------------------------------
  // shutdown status and thermal warning
  // ------------------------------------------------------------------

  logic fault_q;
  logic fault_d;
  logic warn_q;
  logic warn_d;

  wire fault_set;
  wire fault_clr;

  // sticky until standby low or power lost; set wins
  assign fault_set = overcurrent_s | overheat_s;
  assign fault_clr = ~standby_s | ~power_ok_s;
  assign fault_d = fault_set | (fault_q & ~fault_clr);

  // hysteresis: hot sets, cooled past release clears
  assign warn_d = hot_s | (warn_q & ~cool_s);

  // status flops
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fault_q <= 1'b0;
      warn_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
      warn_q <= warn_d;
    end
  end

  // open-drain flags pull low when enabled
  assign FAULT_N_O = 1'b0;
  assign FAULT_N_OE_N = ~fault_q;
  assign THERMAL_WARN_N_O = 1'b0;
  assign THERMAL_WARN_N_OE_N = ~warn_q;

  // ------------------------------------------------------------------
  // motor control from the gated storage word
  // ------------------------------------------------------------------

  ctrl_word_s ctrl;

  wire run;
  wire brake_cc;
  wire brake_all;
  wire on_a;
  wire on_b;

  // gate high blanks every stored bit
  assign ctrl = gate_s ? ctrl_word_s'(`STP_WORD_RST) : ctrl_word_s'(store_q);

  // operating modes
  assign run = (state_q == ST_RUN) & ~fault_q;
  assign brake_cc = brake_s & cc_s;
  assign brake_all = brake_s & ~cc_s;

  // channel on when enabled or held by constant-current brake
  assign on_a = ctrl.drive_on_a | brake_cc;
  assign on_b = ctrl.drive_on_b | brake_cc;

  bridge_s bridge_d;
  bridge_s bridge_q;
  logic [`STP_PCT_W-1:0] pct_d;
  logic [`STP_PCT_W-1:0] pct_q;
  logic osc_q;

  // bridge selection
  always_comb begin
    bridge_d = '0;
    if (!run) begin
      bridge_d = '0;
    end else if (brake_all) begin
      bridge_d = '1;
    end else begin
      {bridge_d.a_pos, bridge_d.a_neg} = chan_drive(on_a, ctrl.polarity_a);
      {bridge_d.b_pos, bridge_d.b_neg} = chan_drive(on_b, ctrl.polarity_b);
    end
  end

  // current setting
  always_comb begin
    pct_d = `STP_PCT_RST;
    if (!run) begin
      pct_d = `STP_PCT_RST;
    end else if (brake_cc) begin
      pct_d = `STP_PCT_FULL;
    end else begin
      pct_d = trq_ratio(ctrl.torque);
    end
  end

  // registered motor outputs
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      bridge_q <= '0;
      pct_q <= `STP_PCT_RST;
      osc_q <= 1'b0;
    end else begin
      bridge_q <= bridge_d;
      pct_q <= pct_d;
      osc_q <= (state_d != ST_SLEEP);
    end
  end

  assign BRIDGE_ON = bridge_q;
  assign CURRENT_PCT = pct_q;
  assign OSC_RUN = osc_q;

endmodule

/* stp_properties.sv */
// assertion checker of the serial stepper control logic
`timescale 1ns/1ns
`include "stp_map.svh"
module stp_properties (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic LINK_CLK,
  input wire logic LATCH,
  input wire logic REGISTER_CLEAR_N,
  input wire logic GATE,
  input wire logic BRAKE,
  input wire logic STANDBY,
  input wire logic CC_ACTIVE,
  input wire logic MOTOR_POWER_OK,
  input wire logic OVERCURRENT_DET,
  input wire logic OVERHEAT_DET,
  input wire logic TEMP_HOT,
  input wire logic TEMP_COOL,
  input wire logic CHAIN_DATA_OUT,
  input wire logic CHAINED_CLOCK_OUT,
  input wire logic CHAINED_LATCH_OUT,
  input wire stp_pkg::bridge_s BRIDGE_ON,
  input wire logic [`STP_PCT_W-1:0] CURRENT_PCT,
  input wire logic OSC_RUN,
  input wire logic FAULT_N_O,
  input wire logic FAULT_N_OE_N,
  input wire logic THERMAL_WARN_N_O,
  input wire logic THERMAL_WARN_N_OE_N
);
  import stp_pkg::*;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);
  // brake modes held long enough to pass the synchronisers
  sequence s_brake_cc;
    (BRAKE && CC_ACTIVE)[*5] ##0 (BRIDGE_ON != 4'h0);
  endsequence
  sequence s_brake_free;
    (BRAKE && !CC_ACTIVE)[*5] ##0 (BRIDGE_ON != 4'h0);
  endsequence
  property p_clear;
    !REGISTER_CLEAR_N |-> !CHAIN_DATA_OUT;
  endproperty
  property p_chain;
    CHAINED_CLOCK_OUT == LINK_CLK && CHAINED_LATCH_OUT == LATCH;
  endproperty
  property p_gate;
    (GATE && !BRAKE)[*5] |-> BRIDGE_ON == 4'h0 && CURRENT_PCT == 7'h00;
  endproperty
  property p_brake_cc;
    s_brake_cc |-> CURRENT_PCT == `STP_PCT_FULL;
  endproperty
  property p_brake_free;
    s_brake_free |-> BRIDGE_ON == 4'hf;
  endproperty
  property p_sleep;
    !STANDBY[*5] |-> !OSC_RUN && BRIDGE_ON == 4'h0;
  endproperty
  property p_fault_set;
    (OVERCURRENT_DET || OVERHEAT_DET)[*5] |-> !FAULT_N_OE_N && !FAULT_N_O;
  endproperty
  property p_fault_hold;
    (STANDBY && MOTOR_POWER_OK)[*5] ##0 !FAULT_N_OE_N |=> !FAULT_N_OE_N;
  endproperty
  property p_warn;
    TEMP_HOT[*5] |-> !THERMAL_WARN_N_OE_N && !THERMAL_WARN_N_O;
  endproperty
  property p_warn_free;
    (TEMP_COOL && !TEMP_HOT)[*5] |-> THERMAL_WARN_N_OE_N;
  endproperty
  a_clear: assert property (p_clear)
    else $error("chain data not cleared");
  a_chain: assert property (p_chain)
    else $error("forwarded clock or latch differs");
  a_gate: assert property (p_gate)
    else $error("gate did not blank outputs");
  a_brake_cc: assert property (p_brake_cc)
    else $error("brake current not full");
  a_brake_free: assert property (p_brake_free)
    else $error("brake without regulation not all on");
  a_sleep: assert property (p_sleep)
    else $error("outputs active in standby");
  a_fault_set: assert property (p_fault_set)
    else $error("fault flag not pulled");
  a_fault_hold: assert property (p_fault_hold)
    else $error("fault flag released early");
  a_warn: assert property (p_warn)
    else $error("warning flag not pulled");
  a_warn_free: assert property (p_warn_free)
    else $error("warning flag not released");
endmodule

bind stp_top stp_properties u_props (.CLK_SYS, .ARST_N, .LINK_CLK, .LATCH, .REGISTER_CLEAR_N,
  .GATE, .BRAKE, .STANDBY, .CC_ACTIVE, .MOTOR_POWER_OK, .OVERCURRENT_DET, .OVERHEAT_DET,
  .TEMP_HOT, .TEMP_COOL, .CHAIN_DATA_OUT, .CHAINED_CLOCK_OUT, .CHAINED_LATCH_OUT, .BRIDGE_ON,
  .CURRENT_PCT, .OSC_RUN, .FAULT_N_O, .FAULT_N_OE_N, .THERMAL_WARN_N_O, .THERMAL_WARN_N_OE_N);

/* stp_host_model.sv */
// controller model: shifts and latches control words
`timescale 1ns/1ns
module stp_host_model (
  input wire logic clk_sys,
  output logic link_clk,
  output logic ser_data,
  output logic latch
);
  initial begin
    link_clk = 1'b0;
    ser_data = 1'b0;
    latch = 1'b0;
  end
  // eight bits msb first, gap stretches each bit, clock runs only in frames
  task automatic send_word(input logic [7:0] w, input int gap, input bit do_latch);
    @(posedge clk_sys);
    #3;
    for (int i = 7; i >= 0; i--) begin
      ser_data = w[i];
      #(7 + gap);
      link_clk = 1'b1;
      #8;
      link_clk = 1'b0;
    end
    ser_data = ~w[0]; // stale line, not a valid bit
    if (do_latch) begin
      repeat (4) @(posedge clk_sys);
      latch <= 1'b1;
      repeat (3) @(posedge clk_sys);
      latch <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
  endtask
endmodule

/* stp_top_tb_top.sv */
// self-checking bench of the serial stepper control logic
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module stp_top_tb_top;
  import stp_pkg::*;
  logic clk_sys, arst_n, link_clk, ser_data, latch, register_clear_n, gate, brake;
  logic standby, cc_active, motor_power_ok, overcurrent_det, overheat_det, temp_hot, temp_cool;
  logic chain_data_out, chained_clock_out, chained_latch_out, osc_run;
  logic fault_n_o, fault_n_oe_n, thermal_warn_n_o, thermal_warn_n_oe_n;
  bridge_s bridge_on;
  logic [6:0] current_pct;
  logic [7:0] w;
  int err_total = 0;
  int checked = 0;
  int cyc = 0;
  localparam logic [6:0] PCT [16] = '{7'h00, 7'h05, 7'h0a, 7'h0f, 7'h19, 7'h1d, 7'h26, 7'h2b,
    7'h34, 7'h3c, 7'h43, 7'h4a, 7'h50, 7'h56, 7'h5e, 7'h64};
  stp_top uut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .LINK_CLK(link_clk), .SER_DATA(ser_data),
    .LATCH(latch), .REGISTER_CLEAR_N(register_clear_n), .GATE(gate), .BRAKE(brake),
    .STANDBY(standby), .CC_ACTIVE(cc_active), .MOTOR_POWER_OK(motor_power_ok),
    .OVERCURRENT_DET(overcurrent_det), .OVERHEAT_DET(overheat_det), .TEMP_HOT(temp_hot),
    .TEMP_COOL(temp_cool), .CHAIN_DATA_OUT(chain_data_out), .CHAINED_CLOCK_OUT(chained_clock_out),
    .CHAINED_LATCH_OUT(chained_latch_out), .BRIDGE_ON(bridge_on), .CURRENT_PCT(current_pct),
    .OSC_RUN(osc_run), .FAULT_N_O(fault_n_o), .FAULT_N_OE_N(fault_n_oe_n),
    .THERMAL_WARN_N_O(thermal_warn_n_o), .THERMAL_WARN_N_OE_N(thermal_warn_n_oe_n));
  stp_host_model host (.clk_sys(clk_sys), .link_clk(link_clk), .ser_data(ser_data),
    .latch(latch));
  // system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic test_done();
    $display("checked=%0d errors=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    {arst_n, gate, brake, standby, cc_active, overcurrent_det} = 6'h00;
    {overheat_det, temp_hot, temp_cool} = 3'h0;
    {register_clear_n, motor_power_ok} = 2'h3;
    wait_cyc(6);
    arst_n <= 1'b1;
    standby <= 1'b1;
    cc_active <= 1'b1;
    wait_cyc(520);
    // every torque code, both polarities, prompt and slow link
    for (int c = 0; c < 16; c++) begin
      w = {c[0], c[1], c[2], c[3], 1'b1, ~c[0], 1'b1, c[0]};
      host.send_word(w, (c % 2) * 20, 1'b1);
      wait_cyc(2);
      `CHK(chain_data_out, w[7])
      `CHK(bridge_on, {c[0], ~c[0], ~c[0], c[0]})
      `CHK(current_pct, PCT[c])
    end
    // shifting alone leaves the outputs alone
    host.send_word(8'h00, 0, 1'b0);
    wait_cyc(8);
    `CHK(bridge_on, 4'b1001)
    `CHK(chain_data_out, 1'b0)
    `CHK(chained_clock_out, 1'b0)
    `CHK(chained_latch_out, 1'b0)
    gate <= 1'b1;
    wait_cyc(6);
    `CHK(bridge_on, 4'h0)
    gate <= 1'b0;
    wait_cyc(6);
    `CHK(bridge_on, 4'b1001)
    host.send_word(8'hf0, 0, 1'b1);
    wait_cyc(2);
    `CHK(bridge_on, 4'h0)
    // braking, polarity swap, then unregulated brake
    host.send_word(8'h05, 0, 1'b1);
    brake <= 1'b1;
    wait_cyc(6);
    `CHK(current_pct, 7'h64)
    `CHK(bridge_on, 4'b1010)
    host.send_word(8'h00, 0, 1'b1);
    wait_cyc(2);
    `CHK(bridge_on, 4'b0101)
    cc_active <= 1'b0;
    wait_cyc(6);
    `CHK(bridge_on, 4'hf)
    brake <= 1'b0;
    cc_active <= 1'b1;
    // clear zeroes both registers
    host.send_word(8'hff, 0, 1'b1);
    register_clear_n <= 1'b0;
    wait_cyc(6);
    `CHK(bridge_on, 4'h0)
    `CHK(current_pct, 7'h00)
    register_clear_n <= 1'b1;
    host.send_word(8'hff, 0, 1'b1);
    // fault latches, cleared by standby then by motor power
    overcurrent_det <= 1'b1;
    wait_cyc(6);
    `CHK(fault_n_oe_n, 1'b0)
    `CHK(bridge_on, 4'h0)
    `CHK(fault_n_o, 1'b0)
    overcurrent_det <= 1'b0;
    wait_cyc(6);
    `CHK(fault_n_oe_n, 1'b0)
    standby <= 1'b0;
    wait_cyc(6);
    `CHK(fault_n_oe_n, 1'b1)
    `CHK(osc_run, 1'b0)
    standby <= 1'b1;
    wait_cyc(520);
    `CHK(bridge_on, 4'b1010)
    overheat_det <= 1'b1;
    wait_cyc(6);
    `CHK(fault_n_oe_n, 1'b0)
    overheat_det <= 1'b0;
    motor_power_ok <= 1'b0;
    wait_cyc(6);
    `CHK(fault_n_oe_n, 1'b1)
    motor_power_ok <= 1'b1;
    // warning pulls, holds, releases when cool
    temp_hot <= 1'b1;
    wait_cyc(6);
    `CHK(thermal_warn_n_oe_n, 1'b0)
    `CHK(thermal_warn_n_o, 1'b0)
    temp_hot <= 1'b0;
    wait_cyc(6);
    `CHK(thermal_warn_n_oe_n, 1'b0)
    temp_cool <= 1'b1;
    wait_cyc(6);
    `CHK(thermal_warn_n_oe_n, 1'b1)
    test_done();
  end
endmodule
